// ---- ptmr_defs.vh ----
`ifndef PTMR_DEFS_VH
`define PTMR_DEFS_VH
// register byte addresses (one aligned word each)
`define PTMR_CTRL0_ADDR 6'h00
`define PTMR_CTRL1_ADDR 6'h04
`define PTMR_CNTL_ADDR 6'h08
`define PTMR_CNTH_ADDR 6'h0c
`define PTMR_CMPAL_ADDR 6'h10
`define PTMR_CMPAH_ADDR 6'h14
`define PTMR_CMPPL_ADDR 6'h18
`define PTMR_CMPPH_ADDR 6'h1c
`define PTMR_FLAG_ADDR 6'h20
// primary control fields
`define PTMR_PAUSE_BIT 7
`define PTMR_CKSEL_HI 6
`define PTMR_CKSEL_LO 4
`define PTMR_RUN_BIT 3
`define PTMR_CTRL0_MASK 8'hf8
// secondary control fields
`define PTMR_MODE_HI 7
`define PTMR_MODE_LO 6
`define PTMR_PINF_HI 5
`define PTMR_PINF_LO 4
`define PTMR_OLVL_BIT 3
`define PTMR_INV_BIT 2
`define PTMR_CAPS_BIT 1
`define PTMR_CLRS_BIT 0
// modes
`define PTMR_MODE_CMP 2'b00
`define PTMR_MODE_CAP 2'b01
`define PTMR_MODE_PWM 2'b10
`define PTMR_MODE_TC 2'b11
// clock selects
`define PTMR_CK_SYS4 3'b000
`define PTMR_CK_SYS 3'b001
`define PTMR_CK_H16 3'b010
`define PTMR_CK_H64 3'b011
`define PTMR_CK_SUB0 3'b100
`define PTMR_CK_SUB1 3'b101
`define PTMR_CK_EXTR 3'b110
`define PTMR_CK_EXTF 3'b111
// prescaler divides
`define PTMR_DIV4 8'h03
`define PTMR_DIV16 8'h0f
`define PTMR_DIV64 8'h3f
`define PTMR_RESET8 8'h00
`define PTMR_RESET16 16'h0000
// axi responses
`define PTMR_RESP_OKAY 2'b00
`define PTMR_RESP_SLVERR 2'b10
`endif

// ---- ptmr_edge.v ----
`default_nettype none
// edge detector on a synchronous input
module ptmr_edge (
   input wire CORE_CLK,
   input wire RESET,
   input wire din,
   output wire rise,
   output wire fall
);
   reg prev_q; // last sampled level
   // sample level each clock
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= din;
      end
   end
   assign rise = din & ~prev_q;
   assign fall = ~din & prev_q;
endmodule
`default_nettype wire

// ---- ptmr_presc.v ----
`default_nettype none
`include "ptmr_defs.vh"
// free running prescaler: one-cycle tick per divided period
module ptmr_presc (
   input wire CORE_CLK,
   input wire RESET,
   input wire hclk_tick,
   output wire tick_div4,
   output wire tick_h16,
   output wire tick_h64
);
   reg [7:0] sys_q; // system clock divider
   reg [7:0] h_q; // high clock divider, advanced on hclk_tick
   // both dividers run always; cheap and keeps phase simple
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         sys_q <= `PTMR_RESET8;
         h_q <= `PTMR_RESET8;
      end else begin
         sys_q <= (sys_q == `PTMR_DIV4) ? `PTMR_RESET8 : sys_q + 8'h01;
         if (hclk_tick) begin
            h_q <= (h_q == `PTMR_DIV64) ? `PTMR_RESET8 : h_q + 8'h01;
         end
      end
   end
   assign tick_div4 = (sys_q == `PTMR_DIV4);
   assign tick_h16 = hclk_tick & ((h_q & `PTMR_DIV16) == `PTMR_DIV16);
   assign tick_h64 = hclk_tick & (h_q == `PTMR_DIV64);
endmodule
`default_nettype wire

// ---- ptmr_top.v ----
`default_nettype none
`include "ptmr_defs.vh"
// What this block does
// R1: 16-bit up-counter, selectable count clock
// R2: comparators A and P on 16 bits
// R3: software clears counter only by run rise
// R4: pause bit holds count, resume later
// R5: 3-bit clock select decoding
// R6: run rise clears and starts; fall holds
// R7: run rise loads output initial level
// R8: 2-bit mode field selects operation
// R9: software stops module before mode change
// R10: compare mode pin action on A match
// R11: PWM mode pin-function decoding
// R12: capture edge select, or disabled
// R13: requested level equal initial: no change
// R14: change PWM pin-function only when off
// R15: output-level bit meaning per mode
// R16: invert bit flips pin, not timer mode
// R17: capture source pin select
// R18: clear on A or on P/overflow
// R19: clear select ignored outside compare modes
// R20: count readable, compare values read/write
// R21: interrupt request on counter clear
// R22: timer/counter mode leaves pin undriven
// R23: P flag only with clear select 0, or in PWM mode
// R24: A zero: overflow at FFFF, no A flag
// R25: PWM period from P, 0 means 65536
// R26: duty at or above period gives 100%
// R27: capture copies count into A, flags A
module ptmr_top (
   input wire CORE_CLK,
   input wire RESET,
   // axi4-lite slave
   input wire [5:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output wire [1:0] S_AXI_BRESP,
   output wire S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [5:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output wire [31:0] S_AXI_RDATA,
   output wire [1:0] S_AXI_RRESP,
   output wire S_AXI_RVALID,
   input wire S_AXI_RREADY,
   // clock enables of the other internal clocks
   input wire HIGH_CLOCK_TICK,
   input wire SUB_CLOCK_TICK,
   // pins
   input wire EXT_COUNT_PIN,
   input wire CAPTURE_INPUT_PIN,
   output wire TIMER_OUT_PIN,
   output wire TIMER_OUT_PIN_OE_N,
   output wire MATCH_IRQ
);
   // control registers
   reg [7:0] ctrl0_q; // pause, clock select, run
   reg [7:0] ctrl1_q; // mode, pin function, level, invert, sources
   reg [15:0] cmpa_q; // comparator A value
   reg [15:0] cmpp_q; // comparator P value
   reg [15:0] cnt_q; // the counter
   reg out_q; // internal output level before invert
   reg flag_a_q; // sticky A match flag
   reg flag_p_q; // sticky P match flag
   reg irq_q; // one-cycle interrupt request
   reg run_prev_q; // run bit last cycle, for edge detection
   // bus state
   reg bvalid_q;
   reg rvalid_q;
   reg [31:0] rdata_q;
   reg [1:0] rresp_q;
   reg [1:0] bresp_q;
   reg aw_got_q; // write address latched
   reg w_got_q; // write data latched
   reg [5:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;

   // field views
   wire pause = ctrl0_q[`PTMR_PAUSE_BIT];
   wire [2:0] cksel = ctrl0_q[`PTMR_CKSEL_HI:`PTMR_CKSEL_LO];
   wire run = ctrl0_q[`PTMR_RUN_BIT];
   wire [1:0] mode = ctrl1_q[`PTMR_MODE_HI:`PTMR_MODE_LO];
   wire [1:0] pinf = ctrl1_q[`PTMR_PINF_HI:`PTMR_PINF_LO];
   wire olvl = ctrl1_q[`PTMR_OLVL_BIT];
   wire inv = ctrl1_q[`PTMR_INV_BIT];
   wire caps = ctrl1_q[`PTMR_CAPS_BIT];
   wire clrs = ctrl1_q[`PTMR_CLRS_BIT];

   // edges of pins and run bit
   wire ext_rise, ext_fall, cap_rise, cap_fall;
   wire run_rise = run & ~run_prev_q; // R6
   wire tick_div4, tick_h16, tick_h64;

   ptmr_edge u_ext_edge (
      .CORE_CLK(CORE_CLK),
      .RESET(RESET),
      .din(EXT_COUNT_PIN),
      .rise(ext_rise),
      .fall(ext_fall)
   );

   ptmr_edge u_cap_edge (
      .CORE_CLK(CORE_CLK),
      .RESET(RESET),
      .din(CAPTURE_INPUT_PIN),
      .rise(cap_rise),
      .fall(cap_fall)
   );

   ptmr_presc u_presc (
      .CORE_CLK(CORE_CLK),
      .RESET(RESET),
      .hclk_tick(HIGH_CLOCK_TICK),
      .tick_div4(tick_div4),
      .tick_h16(tick_h16),
      .tick_h64(tick_h64)
   );

   // decode the count clock select into a tick
   function ck_tick;
      input [2:0] sel;
      input t4, t16, t64, tsub, er, ef;
      begin
         case (sel)
            `PTMR_CK_SYS4: ck_tick = t4; // R5
            `PTMR_CK_SYS: ck_tick = 1'b1;
            `PTMR_CK_H16: ck_tick = t16;
            `PTMR_CK_H64: ck_tick = t64;
            `PTMR_CK_SUB0: ck_tick = tsub;
            `PTMR_CK_SUB1: ck_tick = tsub;
            `PTMR_CK_EXTR: ck_tick = er;
            `PTMR_CK_EXTF: ck_tick = ef;
            default: ck_tick = 1'b0;
         endcase
      end
   endfunction

   // decode one edge selection, used for capture
   function edge_hit;
      input [1:0] sel;
      input r, f;
      begin
         case (sel)
            2'b00: edge_hit = r; // R12
            2'b01: edge_hit = f;
            2'b10: edge_hit = r | f;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction

   wire tick = run & ~pause & ck_tick(cksel, tick_div4, tick_h16, tick_h64,
      SUB_CLOCK_TICK, ext_rise, ext_fall); // R1 R4
   wire cap_r = caps ? ext_rise : cap_rise; // R17
   wire cap_f = caps ? ext_fall : cap_fall;
   wire cap_hit = run & (mode == `PTMR_MODE_CAP) & edge_hit(pinf, cap_r, cap_f); // R27

   // comparators look at the count that the tick is about to leave
   wire match_a = tick & (cnt_q == cmpa_q) & (cmpa_q != `PTMR_RESET16); // R2 R24
   wire match_p = tick & (cnt_q == cmpp_q) & (cmpp_q != `PTMR_RESET16); // R2
   wire ovf = tick & (cnt_q == 16'hffff);
   wire cmp_like = (mode == `PTMR_MODE_CMP) | (mode == `PTMR_MODE_TC);
   wire is_pwm = (mode == `PTMR_MODE_PWM);
   // counter clear cause per mode
   // a zero compare value means the wrap itself is the clear, so it still interrupts
   wire ovf_a = ovf & (cmpa_q == `PTMR_RESET16); // R24 R21
   wire ovf_p = ovf & (cmpp_q == `PTMR_RESET16);
   wire clr_cmp = clrs ? (match_a | ovf_a) : (match_p | ovf_p); // R18
   wire clr_pwm = match_p | ovf_p; // R19 R25
   wire clr_now = cmp_like ? clr_cmp : (is_pwm ? clr_pwm : ovf);
   wire set_a = cap_hit | (match_a & (is_pwm | cmp_like)); // R27
   wire set_p = match_p & (is_pwm | (cmp_like & ~clrs)); // R23

   // counter
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         cnt_q <= `PTMR_RESET16;
         run_prev_q <= 1'b0;
      end else begin
         run_prev_q <= run;
         if (run_rise) begin
            cnt_q <= `PTMR_RESET16; // R3 R6
         end else if (clr_now) begin
            cnt_q <= `PTMR_RESET16;
         end else if (tick) begin
            cnt_q <= cnt_q + 16'h0001; // R1
         end
      end
   end

   // output pin logic; level before invert
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         out_q <= 1'b0;
      end else if (run_rise) begin
         out_q <= olvl; // R7 R15
      end else if (mode == `PTMR_MODE_CMP) begin
         if (match_a) begin
            case (pinf)
               2'b01: out_q <= 1'b0; // R10 R13
               2'b10: out_q <= 1'b1;
               2'b11: out_q <= ~out_q;
               default: out_q <= out_q;
            endcase
         end
      end else if (is_pwm) begin
         case (pinf)
            2'b00: out_q <= ~olvl; // R11
            2'b01: out_q <= olvl;
            2'b10: begin
               // active from period start up to duty, duty>=period: always on
               if (clr_pwm | run_rise) begin
                  out_q <= (cmpa_q != `PTMR_RESET16) ? olvl : ~olvl; // R26
               end else if (match_a) begin
                  out_q <= ~olvl; // R25
               end
            end
            default: begin
               // single pulse: active from run until A match, then idle
               if (match_a) begin
                  out_q <= ~olvl;
               end
            end
         endcase
      end
   end

   assign TIMER_OUT_PIN = out_q ^ inv; // R16
   assign TIMER_OUT_PIN_OE_N = ~((mode == `PTMR_MODE_CMP) | is_pwm); // R22
   assign MATCH_IRQ = irq_q;

   // axi write channel: address and data taken in any order
   wire wr_go = aw_got_q & w_got_q & ~bvalid_q;
   assign S_AXI_AWREADY = ~aw_got_q & ~bvalid_q;
   assign S_AXI_WREADY = ~w_got_q & ~bvalid_q;
   assign S_AXI_BVALID = bvalid_q;
   assign S_AXI_BRESP = bresp_q;
   assign S_AXI_ARREADY = ~rvalid_q;
   assign S_AXI_RVALID = rvalid_q;
   assign S_AXI_RDATA = rdata_q;
   assign S_AXI_RRESP = rresp_q;
   wire wr_a = wr_go & wstrb_q[0];
   wire [7:0] wb = wdata_q[7:0];
   // write decode is a function since the whole-address compare is reused per register
   function hit;
      input [5:0] a, b;
      begin
         hit = (a == b);
      end
   endfunction
   wire mapped_w = hit(awaddr_q, `PTMR_CTRL0_ADDR) | hit(awaddr_q, `PTMR_CTRL1_ADDR) |
      hit(awaddr_q, `PTMR_CNTL_ADDR) | hit(awaddr_q, `PTMR_CNTH_ADDR) |
      hit(awaddr_q, `PTMR_CMPAL_ADDR) | hit(awaddr_q, `PTMR_CMPAH_ADDR) |
      hit(awaddr_q, `PTMR_CMPPL_ADDR) | hit(awaddr_q, `PTMR_CMPPH_ADDR) |
      hit(awaddr_q, `PTMR_FLAG_ADDR);

   // bus write, registers, flags
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= 6'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `PTMR_RESP_OKAY;
         ctrl0_q <= `PTMR_RESET8;
         ctrl1_q <= `PTMR_RESET8;
         cmpa_q <= `PTMR_RESET16;
         cmpp_q <= `PTMR_RESET16;
         flag_a_q <= 1'b0;
         flag_p_q <= 1'b0;
         irq_q <= 1'b0;
      end else begin
         if (S_AXI_AWVALID & S_AXI_AWREADY) begin
            aw_got_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID & S_AXI_WREADY) begin
            w_got_q <= 1'b1;
            wdata_q <= S_AXI_WDATA;
            wstrb_q <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= mapped_w ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
         end else if (bvalid_q & S_AXI_BREADY) begin
            bvalid_q <= 1'b0;
         end
         // counter registers are read only, writes dropped
         if (wr_a & hit(awaddr_q, `PTMR_CTRL0_ADDR)) ctrl0_q <= wb & `PTMR_CTRL0_MASK;
         if (wr_a & hit(awaddr_q, `PTMR_CTRL1_ADDR)) ctrl1_q <= wb; // R8
         if (wr_a & hit(awaddr_q, `PTMR_CMPAL_ADDR)) cmpa_q[7:0] <= wb; // R20
         if (wr_a & hit(awaddr_q, `PTMR_CMPAH_ADDR)) cmpa_q[15:8] <= wb;
         if (wr_a & hit(awaddr_q, `PTMR_CMPPL_ADDR)) cmpp_q[7:0] <= wb;
         if (wr_a & hit(awaddr_q, `PTMR_CMPPH_ADDR)) cmpp_q[15:8] <= wb;
         if (cap_hit) cmpa_q <= cnt_q; // R27
         // flags: write one to clear, a set in the same cycle wins
         if (wr_a & hit(awaddr_q, `PTMR_FLAG_ADDR)) begin
            if (wb[0]) flag_a_q <= 1'b0;
            if (wb[1]) flag_p_q <= 1'b0;
         end
         if (set_a) flag_a_q <= 1'b1;
         if (set_p) flag_p_q <= 1'b1; // R23
         irq_q <= clr_now | set_a | set_p; // R21
      end
   end

   // read data mux
   reg [7:0] rd_byte;
   reg rd_ok;
   always @* begin
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      case (S_AXI_ARADDR)
         `PTMR_CTRL0_ADDR: rd_byte = ctrl0_q;
         `PTMR_CTRL1_ADDR: rd_byte = ctrl1_q;
         `PTMR_CNTL_ADDR: rd_byte = cnt_q[7:0]; // R20
         `PTMR_CNTH_ADDR: rd_byte = cnt_q[15:8];
         `PTMR_CMPAL_ADDR: rd_byte = cmpa_q[7:0];
         `PTMR_CMPAH_ADDR: rd_byte = cmpa_q[15:8];
         `PTMR_CMPPL_ADDR: rd_byte = cmpp_q[7:0];
         `PTMR_CMPPH_ADDR: rd_byte = cmpp_q[15:8];
         `PTMR_FLAG_ADDR: rd_byte = {6'h00, flag_p_q, flag_a_q};
         default: rd_ok = 1'b0;
      endcase
   end

   // read channel, answer one cycle after address taken
   always @(posedge CORE_CLK) begin
      if (RESET) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h00000000;
         rresp_q <= `PTMR_RESP_OKAY;
      end else if (S_AXI_ARVALID & S_AXI_ARREADY) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= rd_ok ? `PTMR_RESP_OKAY : `PTMR_RESP_SLVERR;
      end else if (rvalid_q & S_AXI_RREADY) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- ptmr_chk.sv ----
`default_nettype none
// port-level watcher of the timer block
module ptmr_chk (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic [5:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic S_AXI_RVALID,
   input wire logic TIMER_OUT_PIN,
   input wire logic TIMER_OUT_PIN_OE_N
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pend_q; // write taken last cycle
   logic run_q; // shadow run bit
   logic [5:0] a_q; // last write address
   logic [7:0] d_q; // last write data
   logic [7:0] c1_q; // shadow secondary control
   // shadow lands on the same edge as the block's own registers
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         pend_q <= 1'b0;
         run_q <= 1'b0;
         c1_q <= 8'h00;
      end else begin
         pend_q <= S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;
         if (pend_q && a_q == 6'h00) run_q <= d_q[3];
         if (pend_q && a_q == 6'h04) c1_q <= d_q;
      end
      a_q <= S_AXI_AWADDR;
      d_q <= S_AXI_WDATA[7:0];
   end
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   sequence s_wr_take;
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   endsequence
   sequence s_run_rise;
      pend_q && a_q == 6'h00 && d_q[3] && !run_q && c1_q[7:6] == 2'b00;
   endsequence
   property p_bresp; s_wr_take |-> ##2 S_AXI_BVALID; endproperty
   a_bresp: assert property (p_bresp) else $error("write answer late");
   property p_wbusy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
   a_wbusy: assert property (p_wbusy) else $error("write taken while busy");
   property p_rresp; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
   a_rresp: assert property (p_rresp) else $error("read answer late");
   property p_rbusy; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
   a_rbusy: assert property (p_rbusy) else $error("read taken while busy");
   property p_rdhi; S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0; endproperty
   a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
   property p_oe_off; c1_q[6] && $stable(c1_q) |-> TIMER_OUT_PIN_OE_N; endproperty
   a_oe_off: assert property (p_oe_off) else $error("pin driven in input mode");
   property p_oe_on; !c1_q[6] && $stable(c1_q) |-> !TIMER_OUT_PIN_OE_N; endproperty
   a_oe_on: assert property (p_oe_on) else $error("pin not driven");
   property p_run_lvl; s_run_rise |-> ##[1:2] TIMER_OUT_PIN == (c1_q[3] ^ c1_q[2]); endproperty
   a_run_lvl: assert property (p_run_lvl) else $error("bad start level");
endmodule
bind ptmr_top ptmr_chk ptmr_chk_i (.CORE_CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID,
   .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
   .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .TIMER_OUT_PIN,
   .TIMER_OUT_PIN_OE_N);
`default_nettype wire

// ---- ptmr_top_bench.sv ----
`default_nettype none
module ptmr_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic CORE_CLK = 1'b0, RESET = 1'b1;
   logic [5:0] S_AXI_AWADDR = 6'h00, S_AXI_ARADDR = 6'h00;
   logic [31:0] S_AXI_WDATA = 32'h0;
   logic S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
   logic HIGH_CLOCK_TICK = 1'b0, SUB_CLOCK_TICK = 1'b0;
   logic EXT_COUNT_PIN = 1'b0, CAPTURE_INPUT_PIN = 1'b0;
   wire S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
   wire [1:0] S_AXI_BRESP, S_AXI_RRESP;
   wire [31:0] S_AXI_RDATA;
   wire TIMER_OUT_PIN, TIMER_OUT_PIN_OE_N, MATCH_IRQ;
   int errors = 0, tests_run = 0, cyc = 0, irqs = 0, n0;
   logic [15:0] c;
   logic [7:0] rv;
   logic [1:0] rr;
   logic [2:0] kb;
   logic lv;
   // pwm table, entry j in the low end: control, duty, pulses, level
   logic [63:0] pc = 64'hb8b8ac9888a8a8a8, pa = 64'h0202020202050202;
   logic [31:0] pn = 32'h31131731;
   logic [7:0] pe = 8'h55;
   // strobe and response ready are held up, only byte lane 0 matters
   ptmr_top ptmr_top_i (.CORE_CLK, .RESET, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
      .S_AXI_WDATA, .S_AXI_WSTRB(4'h1), .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
      .S_AXI_BVALID, .S_AXI_BREADY(1'b1), .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY,
      .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY(1'b1), .HIGH_CLOCK_TICK,
      .SUB_CLOCK_TICK, .EXT_COUNT_PIN, .CAPTURE_INPUT_PIN, .TIMER_OUT_PIN,
      .TIMER_OUT_PIN_OE_N, .MATCH_IRQ);
   always #5 CORE_CLK = ~CORE_CLK;
   // tick sources, irq tally and hang guard
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      HIGH_CLOCK_TICK <= cyc[0];
      SUB_CLOCK_TICK <= (cyc[2:0] == 3'd0);
      if (MATCH_IRQ === 1'b1) irqs <= irqs + 1;
      if (cyc == 20000) begin
         errors = errors + 1;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rng(input logic [15:0] got, input int lo, input int hi);
      tests_run++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("[ERR] %0t got %h exp %h..%h", $time, got, lo, hi);
      end
   endtask
   // one write: address and data offered together, wait for the answer
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= {24'h0, d};
      S_AXI_AWVALID <= 1'b1;
      S_AXI_WVALID <= 1'b1;
      while (aw || w) begin
         @(posedge CORE_CLK);
         if (aw && S_AXI_AWREADY) begin
            aw = 1'b0;
            S_AXI_AWVALID <= 1'b0;
         end
         if (w && S_AXI_WREADY) begin
            w = 1'b0;
            S_AXI_WVALID <= 1'b0;
         end
      end
      do @(posedge CORE_CLK); while (S_AXI_BVALID !== 1'b1);
      rr = S_AXI_BRESP;
   endtask
   task automatic rd(input logic [5:0] a);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1'b1;
      do @(posedge CORE_CLK); while (S_AXI_ARREADY !== 1'b1);
      S_AXI_ARVALID <= 1'b0;
      do @(posedge CORE_CLK); while (S_AXI_RVALID !== 1'b1);
      rv = S_AXI_RDATA[7:0];
      rr = S_AXI_RRESP;
   endtask
   task automatic rc(input logic [5:0] a, input logic [7:0] e);
      rd(a);
      chk(rv, e);
   endtask
   // count read as two bytes, only while it stands still
   task automatic cnt();
      rd(6'h08);
      c[7:0] = rv;
      rd(6'h0c);
      c[15:8] = rv;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         EXT_COUNT_PIN <= 1'b1;
         repeat (4) @(posedge CORE_CLK);
         EXT_COUNT_PIN <= 1'b0;
         repeat (4) @(posedge CORE_CLK);
      end
   endtask
   task automatic cap(input logic l);
      CAPTURE_INPUT_PIN <= l;
      repeat (4) @(posedge CORE_CLK);
   endtask
   initial begin
      repeat (20) @(posedge CORE_CLK);
      RESET <= 1'b0;
      @(posedge CORE_CLK);
      for (int i = 0; i < 4; i++)
         rc(6'(4 * i), 8'h00);
      wr(6'h10, 8'h34);
      wr(6'h14, 8'h12);
      wr(6'h1c, 8'hab);
      rc(6'h10, 8'h34);
      rc(6'h14, 8'h12);
      rc(6'h1c, 8'hab);
      wr(6'h1c, 8'h00);
      wr(6'h08, 8'h55);
      chk(rr, 2'b00);
      rc(6'h08, 8'h00);
      rd(6'h24);
      chk(rr, 2'b10);
      wr(6'h00, 8'hf7);
      rc(6'h00, 8'hf0);
      $display("registers done");
      // each internal source from a fresh start, 512 cycles, then paused
      for (int s = 0; s < 6; s++) begin
         wr(6'h00, {1'b0, 3'(s), 4'h8});
         repeat (512) @(posedge CORE_CLK);
         wr(6'h00, {1'b1, 3'(s), 4'h8});
         cnt();
         n0 = (s == 1) ? 1 : (s == 0) ? 4 : (s == 2) ? 32 : (s == 3) ? 128 : 8;
         rng(c, 512 / n0 - 2, 512 / n0 + 6);
         wr(6'h00, 8'h00);
      end
      wr(6'h00, 8'h68);
      pulse(5);
      cnt();
      chk(c, 16'd5);
      wr(6'h00, 8'h78);
      pulse(2);
      cnt();
      chk(c, 16'd7);
      wr(6'h00, 8'hf8);
      pulse(3);
      cnt();
      chk(c, 16'd7);
      wr(6'h00, 8'h78);
      pulse(1);
      cnt();
      chk(c, 16'd8);
      wr(6'h00, 8'h70);
      pulse(2);
      cnt();
      chk(c, 16'd8);
      wr(6'h00, 8'h78);
      cnt();
      chk(c, 16'd0);
      $display("counting done");
      // compare output: every pin action against both start levels
      wr(6'h10, 8'h03);
      wr(6'h14, 8'h00);
      for (int k = 0; k < 8; k++) begin
         kb = 3'(k);
         wr(6'h00, 8'h00);
         wr(6'h04, {2'b00, kb[1:0], kb[2], kb[0], 2'b01});
         wr(6'h20, 8'h03);
         wr(6'h00, 8'h68);
         @(posedge CORE_CLK);
         chk(TIMER_OUT_PIN, kb[2] ^ kb[0]);
         n0 = irqs;
         pulse(4);
         lv = (kb[1:0] == 2'b11) ? ~kb[2] : (kb[1:0] == 2'b00) ? kb[2] : kb[1];
         chk(TIMER_OUT_PIN, lv ^ kb[0]);
         rc(6'h20, 8'h01);
         cnt();
         chk(c, 16'd0);
         chk(16'(irqs - n0), 16'd1);
      end
      wr(6'h00, 8'h00);
      wr(6'h04, 8'h00);
      wr(6'h10, 8'h01);
      wr(6'h18, 8'h03);
      wr(6'h20, 8'h03);
      wr(6'h00, 8'h68);
      pulse(4);
      rc(6'h20, 8'h03);
      cnt();
      chk(c, 16'd0);
      wr(6'h00, 8'h00);
      wr(6'h04, 8'hc0);
      @(posedge CORE_CLK);
      chk(TIMER_OUT_PIN_OE_N, 1'b1);
      $display("compare done");
      // capture: edge choice, source choice, disabled
      wr(6'h04, 8'h40);
      wr(6'h00, 8'h68);
      pulse(5);
      cap(1'b1);
      rc(6'h10, 8'h05);
      wr(6'h04, 8'h50);
      pulse(2);
      cap(1'b0);
      rc(6'h10, 8'h07);
      wr(6'h04, 8'h70);
      cap(1'b1);
      cap(1'b0);
      rc(6'h10, 8'h07);
      wr(6'h04, 8'h42);
      wr(6'h00, 8'h78);
      pulse(2);
      rc(6'h10, 8'h08);
      wr(6'h04, 8'h60);
      cap(1'b1);
      rc(6'h10, 8'h09);
      pulse(1);
      cap(1'b0);
      rc(6'h10, 8'h0a);
      $display("capture done");
      // pwm and single pulse, reconfigured only while off
      wr(6'h00, 8'h00);
      wr(6'h18, 8'h04);
      for (int j = 0; j < 8; j++) begin
         wr(6'h00, 8'h00);
         wr(6'h04, pc[8*j+:8]);
         wr(6'h10, pa[8*j+:8]);
         wr(6'h00, 8'h68);
         pulse(int'(pn[4*j+:4]));
         chk(TIMER_OUT_PIN, pe[j]);
      end
      $display("pwm done");
      complete_run();
   end
endmodule
`default_nettype wire
